// [verilog/alb_pkg.sv]
// Purpose: shared constants, types and register map of the arith/logic/branch slice
// Assumes: 16-bit instruction words, 8-bit data, 12-bit data memory address
// Notes:   four phases per instruction cycle, q1 to q4
package alb_pkg;
    // ==================================================================
    // widths
    localparam int ADDR_W = 12;
    localparam int PC_W   = 21;
    localparam int ST_W   = 5;

    // ==================================================================
    // opcode patterns
    localparam logic [5:0] OPC_ADD_CARRY = 6'h08;
    localparam logic [5:0] OPC_AND_FILE  = 6'h05;
    localparam logic [7:0] OPC_AND_LIT   = 8'h0b;
    localparam logic [3:0] OPC_CLR_BIT   = 4'h9;
    localparam logic [7:0] OPC_BR_C      = 8'he2;
    localparam logic [7:0] OPC_BR_NC     = 8'he3;
    localparam logic [7:0] OPC_BR_N      = 8'he6;
    localparam logic [7:0] OPC_BR_NN     = 8'he7;

    // ==================================================================
    // instruction fields and addressing
    localparam int         DEST_BIT    = 9;
    localparam int         ABANK_BIT   = 8;
    localparam int         BSEL_LSB    = 9;
    localparam logic [7:0] ACC_SPLIT   = 8'h60;
    localparam logic [7:0] IDX_LIMIT   = 8'h5f;
    localparam logic [3:0] ACC_LO_BANK = 4'h0;
    localparam logic [3:0] ACC_HI_BANK = 4'hf;

    // ==================================================================
    // status bit positions
    localparam int ST_C  = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z  = 2;
    localparam int ST_OV = 3;
    localparam int ST_N  = 4;

    // ==================================================================
    // register map and reset values
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_BANK_SEL = 8'h04;
    localparam logic [7:0] REG_IDX_BASE = 8'h08;
    localparam logic [7:0] REG_ACC      = 8'h0c;
    localparam logic [7:0] REG_STATUS   = 8'h10;
    localparam logic [7:0] REG_STATE    = 8'h14;
    localparam logic [7:0] RST_ACC      = 8'h00;
    localparam logic [4:0] RST_STATUS   = 5'h00;

    // ==================================================================
    // types
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00, PH_Q2 = 2'b01, PH_Q3 = 2'b11, PH_Q4 = 2'b10
    } alb_phase_e;
    typedef enum logic [2:0] {
        OP_NOP = 3'h0, OP_ADDC = 3'h1, OP_ANDL = 3'h2,
        OP_ANDF = 3'h3, OP_BCLR = 3'h4, OP_BR = 3'h5
    } alb_op_e;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              rd;
        logic              wr;
        logic [7:0]        wdata;
    } alb_mem_req_s;
    typedef struct packed {
        logic            load;
        logic [PC_W-1:0] target;
    } alb_pc_req_s;
endpackage : alb_pkg

// [verilog/alb_exec.sv]
// Purpose: decode and execute of add-carry, and, clear-bit and flag branches
// Assumes: memory read data valid in q3 after a q2 read strobe
// Notes:   registers over a zero-wait ahb-lite slave
// Contract
// - add-carry sums acc, file and carry
// - add-carry updates n, ov, c, dc, z
// - dest bit picks acc or file
// - access bit picks access bank or bank select
// - extended mode indexes addresses up to 5fh
// - and-literal ands literal into acc
// - and ops touch only n and z
// - and-file ands acc with file to dest
// - clear-bit clears selected bit, no flags
// - branch on carry set
// - branch on carry clear, else fall through
// - branch on negative set
// - branch on negative clear
// - target is incremented pc plus twice offset
// - taken branch writes pc, then one nop cycle
//
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module alb_exec
    import alb_pkg::*;
(
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    // ahb-lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // instruction and program counter
    input  wire logic [15:0]          instr_word,
    input  wire logic [PC_W-1:0]      pc_inc,
    output alb_pc_req_s               pc_req,
    output logic                      nop_cycle,
    output alb_phase_e                phase,
    // banked data memory
    output alb_mem_req_s              mem_req,
    input  wire logic [7:0]           mem_rdata
);
    // ==================================================================
    // state
    alb_phase_e         phase_ff;
    alb_op_e            op_ff;
    logic [15:0]        ir_ff;
    logic [7:0]         acc_ff;
    logic [ST_W-1:0]    status_ff;
    logic [7:0]         res_ff;
    logic [ST_W-1:0]    nst_ff;
    logic               upd_acc_ff;
    logic               in_nop_ff;
    logic               ext_en_ff;
    logic [3:0]         bsr_ff;
    logic [ADDR_W-1:0]  idx_base_ff;
    alb_mem_req_s       mem_req_ff;
    alb_pc_req_s        pc_req_ff;
    logic               wr_pend_ff;
    logic [7:0]         wr_ofs_ff;
    logic [31:0]        hrdata_ff;
    logic               hreadyout_ff;

    assign phase     = phase_ff;
    assign mem_req   = mem_req_ff;
    assign pc_req    = pc_req_ff;
    assign nop_cycle = in_nop_ff;
    assign hrdata    = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp     = 1'b0;

    // ==================================================================
    // phase sequencer
    wire         in_q1 = phase_ff == PH_Q1;
    wire         in_q2 = phase_ff == PH_Q2;
    wire         in_q3 = phase_ff == PH_Q3;
    wire         in_q4 = phase_ff == PH_Q4;
    alb_phase_e  nxt_phase;
    always_comb begin
        case (phase_ff)
            PH_Q1:   nxt_phase = PH_Q2;
            PH_Q2:   nxt_phase = PH_Q3;
            PH_Q3:   nxt_phase = PH_Q4;
            PH_Q4:   nxt_phase = PH_Q1;
            default: nxt_phase = PH_Q1;
        endcase
    end

    // ==================================================================
    // q1 decode of the incoming word
    wire       is_addc = instr_word[15:10] == OPC_ADD_CARRY;
    wire       is_andf = instr_word[15:10] == OPC_AND_FILE;
    wire       is_andl = instr_word[15:8] == OPC_AND_LIT;
    wire       is_bclr = instr_word[15:12] == OPC_CLR_BIT;
    wire [7:0] hi_byte = instr_word[15:8];
    wire       is_br   = hi_byte == OPC_BR_C || hi_byte == OPC_BR_NC ||
                         hi_byte == OPC_BR_N || hi_byte == OPC_BR_NN;
    // unknown words run as nop; other slices own them
    wire alb_op_e dec_op = in_nop_ff ? OP_NOP :
                           is_addc ? OP_ADDC : is_andf ? OP_ANDF :
                           is_andl ? OP_ANDL : is_bclr ? OP_BCLR :
                           is_br ? OP_BR : OP_NOP;
    wire       dec_file = dec_op == OP_ADDC || dec_op == OP_ANDF || dec_op == OP_BCLR;

    // ==================================================================
    // file address
    wire [7:0]        f_fld    = instr_word[7:0];
    wire              a_bit    = instr_word[ABANK_BIT];
    wire              idx_mode = !a_bit && ext_en_ff && f_fld <= IDX_LIMIT;
    wire [ADDR_W-1:0] idx_addr = idx_base_ff + {4'h0, f_fld};
    wire [ADDR_W-1:0] acc_addr = (f_fld < ACC_SPLIT) ? {ACC_LO_BANK, f_fld}
                                                     : {ACC_HI_BANK, f_fld};
    wire [ADDR_W-1:0] bsr_addr = {bsr_ff, f_fld};
    wire [ADDR_W-1:0] file_addr = a_bit ? bsr_addr :
                                  idx_mode ? idx_addr : acc_addr;

    // ==================================================================
    // q3 processing
    wire       c_in     = status_ff[ST_C];
    wire [4:0] nib_sum  = {1'b0, acc_ff[3:0]} + {1'b0, mem_rdata[3:0]} + {4'h0, c_in};
    wire [8:0] sum9     = {1'b0, acc_ff} + {1'b0, mem_rdata} + {8'h00, c_in};
    wire [7:0] bit_mask = 8'h01 << ir_ff[BSEL_LSB +: 3];
    wire [7:0] result   = (op_ff == OP_ADDC) ? sum9[7:0] :
                          (op_ff == OP_ANDL) ? (acc_ff & ir_ff[7:0]) :
                          (op_ff == OP_ANDF) ? (acc_ff & mem_rdata) :
                          (mem_rdata & ~bit_mask);
    wire       d_bit    = ir_ff[DEST_BIT];
    wire       to_file  = ((op_ff == OP_ADDC || op_ff == OP_ANDF) && d_bit) ||
                          op_ff == OP_BCLR;
    wire       to_acc   = ((op_ff == OP_ADDC || op_ff == OP_ANDF) && !d_bit) ||
                          op_ff == OP_ANDL;
    wire       ov_flag  = (acc_ff[7] == mem_rdata[7]) && (sum9[7] != acc_ff[7]);
    logic [ST_W-1:0] nst;
    always_comb begin
        nst = status_ff;
        if (op_ff == OP_ADDC) begin
            nst[ST_C]  = sum9[8];
            nst[ST_DC] = nib_sum[4];
            nst[ST_OV] = ov_flag;
        end
        if (op_ff == OP_ADDC || op_ff == OP_ANDL || op_ff == OP_ANDF) begin
            nst[ST_N] = result[7];
            nst[ST_Z] = result == 8'h00;
        end
    end

    // ==================================================================
    // branch decision and target
    wire [7:0]      br_code = ir_ff[15:8];
    wire            br_cond = (br_code == OPC_BR_C)  ?  status_ff[ST_C] :
                              (br_code == OPC_BR_NC) ? !status_ff[ST_C] :
                              (br_code == OPC_BR_N)  ?  status_ff[ST_N] :
                                                       !status_ff[ST_N];
    wire            br_take = op_ff == OP_BR && br_cond;
    wire [PC_W-1:0] br_ofs  = {{(PC_W-9){ir_ff[7]}}, ir_ff[7:0], 1'b0};
    wire [PC_W-1:0] br_tgt  = pc_inc + br_ofs;

    // ==================================================================
    // ahb-lite decode
    wire        acc_req   = hsel && htrans[1] && hready;
    wire [7:0]  rd_ofs    = haddr[7:0];
    wire        sw_wr     = wr_pend_ff;
    wire        commit    = in_q4;
    wire        nxt_ext   = (sw_wr && wr_ofs_ff == REG_CTRL) ? hwdata[0] : ext_en_ff;
    wire [3:0]  nxt_bsr   = (sw_wr && wr_ofs_ff == REG_BANK_SEL) ? hwdata[3:0] : bsr_ff;
    wire [ADDR_W-1:0] nxt_idx = (sw_wr && wr_ofs_ff == REG_IDX_BASE) ?
                                hwdata[ADDR_W-1:0] : idx_base_ff;
    // execution commit beats a software write in the same cycle
    wire [7:0]  nxt_acc   = (commit && upd_acc_ff) ? res_ff :
                            (sw_wr && wr_ofs_ff == REG_ACC) ? hwdata[7:0] : acc_ff;
    wire [ST_W-1:0] nxt_status = commit ? nst_ff :
                            (sw_wr && wr_ofs_ff == REG_STATUS) ? hwdata[ST_W-1:0] : status_ff;
    // reads see the value after any write in its data phase
    wire [31:0] rd_mux =
        (rd_ofs == REG_CTRL)     ? {31'h0, nxt_ext} :
        (rd_ofs == REG_BANK_SEL) ? {28'h0, nxt_bsr} :
        (rd_ofs == REG_IDX_BASE) ? {{(32-ADDR_W){1'b0}}, nxt_idx} :
        (rd_ofs == REG_ACC)      ? {24'h0, nxt_acc} :
        (rd_ofs == REG_STATUS)   ? {{(32-ST_W){1'b0}}, nxt_status} :
        (rd_ofs == REG_STATE)    ? {26'h0, in_nop_ff, op_ff, phase_ff} : 32'h0;

    // ==================================================================
    // bus slave registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_ff   <= 1'b0;
            wr_ofs_ff    <= 8'h00;
            hrdata_ff    <= 32'h0;
            hreadyout_ff <= 1'b0;
        end else begin
            wr_pend_ff   <= acc_req && hwrite;
            wr_ofs_ff    <= acc_req ? haddr[7:0] : wr_ofs_ff;
            hrdata_ff    <= (acc_req && !hwrite) ? rd_mux : 32'h0;
            hreadyout_ff <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_en_ff   <= 1'b0;
            bsr_ff      <= 4'h0;
            idx_base_ff <= '0;
            acc_ff      <= RST_ACC;
            status_ff   <= RST_STATUS;
        end else begin
            ext_en_ff   <= nxt_ext;
            bsr_ff      <= nxt_bsr;
            idx_base_ff <= nxt_idx;
            acc_ff      <= nxt_acc;
            status_ff   <= nxt_status;
        end
    end

    // ==================================================================
    // execution pipeline
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_ff <= PH_Q1;
            op_ff    <= OP_NOP;
            ir_ff    <= 16'h0000;
        end else begin
            phase_ff <= nxt_phase;
            op_ff    <= in_q1 ? dec_op : op_ff;
            ir_ff    <= in_q1 ? instr_word : ir_ff;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_req_ff <= '0;
            res_ff     <= 8'h00;
            nst_ff     <= RST_STATUS;
            upd_acc_ff <= 1'b0;
        end else begin
            mem_req_ff.addr  <= in_q1 ? file_addr : mem_req_ff.addr;
            mem_req_ff.rd    <= in_q1 && dec_file;
            mem_req_ff.wr    <= in_q3 && to_file;
            mem_req_ff.wdata <= in_q3 ? result : mem_req_ff.wdata;
            res_ff           <= in_q3 ? result : res_ff;
            // whole status holds pending; unchanged bits copy status at q3
            nst_ff           <= in_q3 ? nst : nst_ff;
            upd_acc_ff       <= in_q3 ? to_acc : (in_q4 ? 1'b0 : upd_acc_ff);
        end
    end

    // taken branch: pc written in q4, following cycle forced to nop
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_req_ff <= '0;
            in_nop_ff <= 1'b0;
        end else begin
            pc_req_ff.load   <= in_q3 && br_take;
            pc_req_ff.target <= (in_q3 && br_take) ? br_tgt : pc_req_ff.target;
            in_nop_ff        <= in_q4 ? pc_req_ff.load : in_nop_ff;
        end
    end

    // ==================================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_ADDC_SUM: assert property (
        (in_q3 && op_ff == OP_ADDC && !d_bit) |-> ##2
        acc_ff == $past(acc_ff, 2) + $past(mem_rdata, 2) + $past(status_ff[ST_C], 2))
        else $error("add-carry result wrong in acc");
    AST_ADDC_CARRY: assert property (
        (in_q3 && op_ff == OP_ADDC) |-> ##2
        (status_ff[ST_C] == $past(sum9[8], 2) && status_ff[ST_DC] == $past(nib_sum[4], 2)))
        else $error("add-carry flags wrong");
    AST_DEST_FILE: assert property (
        (in_q3 && to_file) |=> (mem_req_ff.wr && mem_req_ff.wdata == $past(result)))
        else $error("file destination not written");
    AST_BANK_ADDR: assert property (
        (in_q1 && dec_file && a_bit) |=>
        (mem_req_ff.rd && mem_req_ff.addr == {$past(bsr_ff), $past(instr_word[7:0])}))
        else $error("bank select address wrong");
    AST_IDX_ADDR: assert property (
        (in_q1 && dec_file && idx_mode) |=>
        mem_req_ff.addr == $past(idx_base_ff) + {4'h0, $past(f_fld)})
        else $error("indexed address wrong");
    AST_ANDL_ACC: assert property (
        (in_q3 && op_ff == OP_ANDL) |-> ##2 acc_ff == $past(acc_ff & ir_ff[7:0], 2))
        else $error("and-literal result wrong");
    AST_AND_FLAGS: assert property (
        (in_q3 && (op_ff == OP_ANDL || op_ff == OP_ANDF)) |=>
        (nst_ff[ST_C] == $past(status_ff[ST_C]) && nst_ff[ST_Z] == ($past(result) == 8'h00)))
        else $error("and flags wrong");
    AST_BCLR_BIT: assert property (
        (in_q3 && op_ff == OP_BCLR) |=>
        (mem_req_ff.wr && !mem_req_ff.wdata[$past(ir_ff[BSEL_LSB +: 3])] &&
         nst_ff == $past(status_ff)))
        else $error("clear-bit wrong");
    AST_BR_TARGET: assert property (
        (in_q3 && br_take) |=> (pc_req_ff.load && pc_req_ff.target ==
        $past(pc_inc) + {{(PC_W-9){$past(ir_ff[7])}}, $past(ir_ff[7:0]), 1'b0}))
        else $error("branch target wrong");
    AST_BR_SKIP: assert property (
        (in_q3 && op_ff == OP_BR && !br_cond) |=> !pc_req_ff.load ##1 !in_nop_ff)
        else $error("untaken branch disturbed flow");
    AST_BR_NOP: assert property (
        pc_req_ff.load |=> in_nop_ff [*4] ##1 !in_nop_ff)
        else $error("taken branch nop cycle wrong");
    AST_PHASES: assert property (
        in_q1 |=> in_q2 ##1 in_q3 ##1 in_q4 ##1 in_q1)
        else $error("phase order broken");
    AST_ANDF_RES: assert property (
        (in_q3 && op_ff == OP_ANDF) |=> res_ff == ($past(acc_ff) & $past(mem_rdata)))
        else $error("and-file result wrong");
    AST_BR_CARRY: assert property (
        (in_q3 && op_ff == OP_BR && br_code == OPC_BR_C) |=>
        (pc_req_ff.load == $past(status_ff[ST_C]) && nst_ff == $past(status_ff)))
        else $error("carry-set branch wrong");
    AST_BR_NEG: assert property (
        (in_q3 && op_ff == OP_BR && br_code == OPC_BR_N) |=>
        pc_req_ff.load == $past(status_ff[ST_N]))
        else $error("negative-set branch wrong");
    AST_BR_NNEG: assert property (
        (in_q3 && op_ff == OP_BR && br_code == OPC_BR_NN) |=>
        pc_req_ff.load == !$past(status_ff[ST_N]))
        else $error("negative-clear branch wrong");
endmodule : alb_exec

// [tb/alb_mem_model.sv]
// Purpose: banked data memory and program counter beside the exec slice
// Assumes: synchronous read, data valid the cycle after the read strobe
// Notes:   bench may preload mem and pc_ff by hierarchy between edges
`timescale 1ns/1ps
module alb_mem_model
    import alb_pkg::*;
(
    // clock and reset
    input  wire logic            core_clk,
    input  wire logic            rst_n,
    // memory side
    input  alb_mem_req_s         mem_req,
    output logic      [7:0]      mem_rdata,
    // program counter side
    input  alb_pc_req_s          pc_req,
    output logic      [PC_W-1:0] pc_inc
);
    // ==================================================================
    // storage
    logic [7:0]      mem [0:4095];
    logic [7:0]      last_ff;
    logic            valid_ff;
    logic [PC_W-1:0] pc_ff;

    // plain always: the bench also loads mem and pc_ff directly
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_ff <= 1'b0;
            last_ff  <= 8'h00;
            pc_ff    <= '0;
        end else begin
            valid_ff <= mem_req.rd;
            if (mem_req.rd)
                last_ff <= mem[mem_req.addr];
            if (mem_req.wr)
                mem[mem_req.addr] <= mem_req.wdata;
            if (pc_req.load)
                pc_ff <= pc_req.target;
        end
    end

    // outside the valid cycle the data lines show garbage, not the old byte
    assign mem_rdata = valid_ff ? last_ff : ~last_ff;
    assign pc_inc    = pc_ff + 21'h000002;
endmodule : alb_mem_model

// [tb/test_mcu_arith_logic_branch_exec.sv]
// Purpose: self-checking bench for the arith/logic/branch slice
// Assumes: zero-wait ahb-lite slave, one instruction per four clocks
// Notes:   instr_word is level sampled, so it returns to nop after q1
`timescale 1ns/1ps
module test_mcu_arith_logic_branch_exec
    import alb_pkg::*;
;
    // ==================================================================
    // signals
    logic               core_clk, rst_n, hsel, hwrite, hreadyout, hresp, nop_cycle;
    logic [31:0]        haddr, hwdata, hrdata;
    logic [1:0]         htrans;
    logic [15:0]        instr_word;
    logic [7:0]         mem_rdata;
    logic [PC_W-1:0]    pc_inc;
    alb_pc_req_s        pc_req;
    alb_mem_req_s       mem_req;
    alb_phase_e         phase;
    int                 miscompares, cmp_count, loads, nops;

    alb_exec dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .instr_word(instr_word), .pc_inc(pc_inc), .pc_req(pc_req),
        .nop_cycle(nop_cycle), .phase(phase), .mem_req(mem_req), .mem_rdata(mem_rdata));
    alb_mem_model u_part (.core_clk(core_clk), .rst_n(rst_n), .mem_req(mem_req),
        .mem_rdata(mem_rdata), .pc_req(pc_req), .pc_inc(pc_inc));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // ==================================================================
    // tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] v,
                       output logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= v;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] d;
        bus(a, 1'b1, v, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus(a, 1'b0, 32'h0, d);
    endtask : rd

    // status writes must land on a q1 or q2 edge; q3 snapshot and q4 commit win
    task automatic wr_st(input logic [31:0] v);
        do @(posedge core_clk); while (phase !== PH_Q4);
        wr(REG_STATUS, v);
    endtask : wr_st

    // now=1 puts the word into the very next cycle, e.g. a branch's nop cycle
    task automatic exec(input logic [15:0] w, input bit now);
        if (!now) begin
            do @(posedge core_clk); while (phase !== PH_Q4);
        end
        instr_word <= w;
        @(posedge core_clk);
        instr_word <= 16'h0000;
        repeat (3) @(posedge core_clk);
    endtask : exec

    task automatic run(input logic [15:0] w, input logic [7:0] a0, s0,
                       input logic [11:0] fa, input logic [7:0] fv, a1, s1, f1);
        logic [31:0] d;
        wr(REG_ACC, {24'h0, a0});
        wr_st({24'h0, s0});
        u_part.mem[fa] = fv;
        exec(w, 1'b0);
        rd(REG_ACC, d);
        chk(d, {24'h0, a1});
        rd(REG_STATUS, d);
        chk(d, {24'h0, s1});
        chk({24'h0, u_part.mem[fa]}, {24'h0, f1});
    endtask : run

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    // ==================================================================
    // phase monitor
    always @(posedge core_clk) begin
        if (nop_cycle === 1'b1 && phase === PH_Q4)
            nops++;
        if (pc_req.load === 1'b1) begin
            loads++;
            chk({30'h0, phase}, {30'h0, PH_Q4});
        end
        if (mem_req.rd === 1'b1)
            chk({30'h0, phase}, {30'h0, PH_Q2});
        if (mem_req.wr === 1'b1)
            chk({30'h0, phase}, {30'h0, PH_Q4});
    end

    initial begin
        repeat (8000) @(posedge core_clk);
        miscompares++;
        report_and_stop();
    end

    // ==================================================================
    // main sequence
    initial begin
        logic [31:0]     d;
        logic [7:0]      op, off, sv, ops [4];
        logic            taken;
        logic [PC_W-1:0] tgt;
        int              l0, n0;
        ops = '{8'he2, 8'he3, 8'he6, 8'he7};
        {rst_n, hsel, hwrite, htrans, haddr, hwdata, instr_word} = '0;
        {miscompares, cmp_count, loads, nops} = '0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd(REG_ACC, d);
        chk(d, 32'h0);
        rd(REG_STATUS, d);
        chk(d, 32'h0);
        wr(8'h18, 32'hffffffff);
        rd(8'h18, d);
        chk(d, 32'h0);
        wr(REG_BANK_SEL, 32'hff);
        rd(REG_BANK_SEL, d);
        chk(d, 32'h0f);
        wr(REG_BANK_SEL, 32'h03);
        run(16'h2020, 8'h4d, 8'h01, 12'h020, 8'h02, 8'h50, 8'h02, 8'h02);
        run(16'h2310, 8'h7f, 8'h00, 12'h310, 8'h01, 8'h7f, 8'h1a, 8'h80);
        run(16'h2070, 8'hff, 8'h00, 12'hf70, 8'h01, 8'h00, 8'h07, 8'h01);
        run(16'h1440, 8'h80, 8'h00, 12'h040, 8'hff, 8'h80, 8'h10, 8'hff);
        wr(REG_CTRL, 32'h1);
        wr(REG_IDX_BASE, 32'h200);
        run(16'h1610, 8'hc2, 8'h0b, 12'h210, 8'h17, 8'hc2, 8'h0b, 8'h02);
        run(16'h9e60, 8'h11, 8'h1f, 12'hf60, 8'hc7, 8'h11, 8'h1f, 8'h47);
        wr(REG_CTRL, 32'h0);
        run(16'h0b5f, 8'ha3, 8'h1f, 12'h000, 8'h00, 8'h03, 8'h0b, 8'h00);
        run(16'h0b0f, 8'hf0, 8'h10, 12'h000, 8'h00, 8'h00, 8'h04, 8'h00);
        for (int i = 0; i < 8; i++) begin
            op    = ops[i / 2];
            sv    = i[0] ? 8'h1f : 8'h00;
            off   = i[0] ? 8'h80 : 8'h7f;
            taken = op[0] ^ i[0];
            tgt   = 21'h001002 + {{12{off[7]}}, off, 1'b0};
            wr(REG_ACC, 32'h5a);
            wr_st({24'h0, sv});
            u_part.pc_ff = 21'h001000;
            l0 = loads;
            n0 = nops;
            exec({op, off}, 1'b0);
            exec(16'h0b00, 1'b1);
            rd(REG_ACC, d);
            chk(d, taken ? 32'h5a : 32'h0);
            rd(REG_STATUS, d);
            chk(d, taken ? {24'h0, sv} : {24'h0, (sv & 8'h0f) | 8'h04});
            chk({11'h0, u_part.pc_ff}, {11'h0, taken ? tgt : 21'h001000});
            chk(loads - l0, {31'h0, taken});
            chk(nops - n0, {31'h0, taken});
        end
        report_and_stop();
    end
endmodule : test_mcu_arith_logic_branch_exec
